// *** inc/bfci_consts.vh ***
`ifndef BFCI_CONSTS_VH
`define BFCI_CONSTS_VH

// register byte offsets
`define BFCI_OFS_CMD 8'h00
`define BFCI_OFS_ADDR 8'h04
`define BFCI_OFS_CTRL 8'h08
`define BFCI_OFS_STATUS 8'h0c
`define BFCI_OFS_RDATA 8'h10

// cmd fields
`define BFCI_CMD_READ_BIT 8
// ctrl fields
`define BFCI_CTRL_PDOWN_BIT 0
`define BFCI_CTRL_WAITRDY_BIT 1
// status fields
`define BFCI_ST_BUSY_BIT 0
`define BFCI_ST_READY_BIT 1
`define BFCI_ST_WAKE_BIT 2
`define BFCI_ST_OVALID_BIT 3
`define BFCI_ST_PDOWN_BIT 4

// widths
`define BFCI_ADDR_W 21
`define BFCI_DATA_W 8

// axi responses
`define BFCI_RESP_OKAY 2'h0
`define BFCI_RESP_SLVERR 2'h2

// clock period and times in ns
`define BFCI_CLK_NS 100
`define BFCI_T_SETUP_NS 50
`define BFCI_T_WP_NS 70
`define BFCI_T_ACC_NS 150
`define BFCI_T_RECOV_NS 50
`define BFCI_T_PHQV_NS 400
`define BFCI_T_PHEL_NS 1000

// derived cycle counts, least times round up, at least one
`define BFCI_CYC(ns) (((ns) + `BFCI_CLK_NS - 1) / `BFCI_CLK_NS)
`define BFCI_SETUP_CYC `BFCI_CYC(`BFCI_T_SETUP_NS)
`define BFCI_WP_CYC `BFCI_CYC(`BFCI_T_WP_NS)
`define BFCI_ACC_CYC `BFCI_CYC(`BFCI_T_ACC_NS)
`define BFCI_RECOV_CYC `BFCI_CYC(`BFCI_T_RECOV_NS)
`define BFCI_OVALID_CYC `BFCI_CYC(`BFCI_T_PHQV_NS)
`define BFCI_WAKE_CYC `BFCI_CYC(`BFCI_T_PHEL_NS)

`endif

// *** src/bfci_host.v ***
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "bfci_consts.vh"

module bfci_host (
  // clock and reset
  input wire i_mclk,
  input wire i_reset_n,
  // axi4-lite write address
  input wire i_s_axi_awvalid,
  output reg o_s_axi_awready_ff,
  input wire [7:0] i_s_axi_awaddr,
  // axi4-lite write data
  input wire i_s_axi_wvalid,
  output reg o_s_axi_wready_ff,
  input wire [31:0] i_s_axi_wdata,
  input wire [3:0] i_s_axi_wstrb,
  // axi4-lite write response
  output reg o_s_axi_bvalid_ff,
  input wire i_s_axi_bready,
  output reg [1:0] o_s_axi_bresp_ff,
  // axi4-lite read address
  input wire i_s_axi_arvalid,
  output reg o_s_axi_arready_ff,
  input wire [7:0] i_s_axi_araddr,
  // axi4-lite read data
  output reg o_s_axi_rvalid_ff,
  input wire i_s_axi_rready,
  output reg [31:0] o_s_axi_rdata_ff,
  output reg [1:0] o_s_axi_rresp_ff,
  // flash pins
  output reg [`BFCI_ADDR_W-1:0] o_address_lines_ff,
  output reg [`BFCI_DATA_W-1:0] o_data_lines_ff,
  output reg o_data_lines_oe_ff,
  input wire [`BFCI_DATA_W-1:0] i_data_lines,
  output reg o_chip_select_n_ff,
  output reg o_output_enable_n_ff,
  output reg o_write_strobe_n_ff,
  output reg o_reset_powerdown_n_ff,
  input wire i_ready_busy_out_n
);

  localparam S_IDLE = 3'h0;
  localparam S_SETUP = 3'h1;
  localparam S_STROBE = 3'h2;
  localparam S_HOLD = 3'h3;
  localparam S_RECOV = 3'h4;

  wire [31:0] setup_full = `BFCI_SETUP_CYC;
  wire [31:0] wp_full = `BFCI_WP_CYC;
  wire [31:0] acc_full = `BFCI_ACC_CYC;
  wire [31:0] recov_full = `BFCI_RECOV_CYC;
  wire [31:0] ovalid_full = `BFCI_OVALID_CYC;
  wire [31:0] wake_full = `BFCI_WAKE_CYC;

  reg [2:0] state_ff;
  reg [7:0] cnt_ff;
  reg cur_read_ff;
  reg [`BFCI_DATA_W-1:0] rdata_ff;
  reg [8:0] cmd_ff;
  reg [`BFCI_ADDR_W-1:0] addr_ff;
  reg pdown_ff;
  reg wait_rdy_ff;
  reg cmd_pend_ff;
  reg [11:0] wake_cnt_ff;
  reg [11:0] ovalid_cnt_ff;
  reg aw_hold_ff;
  reg w_hold_ff;
  reg [7:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;

  wire wake_done = (wake_cnt_ff == 12'h000);
  wire ovalid_done = (ovalid_cnt_ff == 12'h000);
  wire dev_ready = i_ready_busy_out_n;
  wire busy = cmd_pend_ff || (state_ff != S_IDLE);
  wire want_read = cmd_ff[`BFCI_CMD_READ_BIT];
  // no cycle while in power-down; reads after reset delay, writes after wake delay
  wire read_ok = ovalid_done;
  // optional wait on ready pin before writes
  wire write_ok = wake_done && (!wait_rdy_ff || dev_ready);
  wire start = cmd_pend_ff && (state_ff == S_IDLE) && !pdown_ff && o_reset_powerdown_n_ff &&
               (want_read ? read_ok : write_ok);
  wire [31:0] wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  wire [31:0] addr_ext = {11'h0, addr_ff};
  wire [31:0] ctrl_ext = {30'h0, wait_rdy_ff, pdown_ff};
  wire [31:0] addr_new = (addr_ext & ~wmask) | (wdata_ff & wmask);
  wire [31:0] ctrl_new = (ctrl_ext & ~wmask) | (wdata_ff & wmask);

  reg [31:0] rd_mux;
  reg rd_err;
  always @* begin
    rd_mux = 32'h00000000;
    rd_err = 1'b0;
    if (i_s_axi_araddr == `BFCI_OFS_CMD) begin
      rd_mux = {23'h0, cmd_ff};
    end else if (i_s_axi_araddr == `BFCI_OFS_ADDR) begin
      rd_mux = addr_ext;
    end else if (i_s_axi_araddr == `BFCI_OFS_CTRL) begin
      rd_mux = ctrl_ext;
    end else if (i_s_axi_araddr == `BFCI_OFS_STATUS) begin
      // status poll: busy, ready pin, delays, power-down
      rd_mux = {27'h0, pdown_ff, ovalid_done, wake_done, dev_ready, busy};
    end else if (i_s_axi_araddr == `BFCI_OFS_RDATA) begin
      rd_mux = {24'h000000, rdata_ff};
    end else begin
      rd_err = 1'b1;
    end
  end

  // axi4-lite write path and register file
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_s_axi_awready_ff <= 1'b1;
      o_s_axi_wready_ff <= 1'b1;
      o_s_axi_bvalid_ff <= 1'b0;
      o_s_axi_bresp_ff <= `BFCI_RESP_OKAY;
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      cmd_ff <= 9'h000;
      addr_ff <= 21'h0;
      pdown_ff <= 1'b0;
      wait_rdy_ff <= 1'b0;
      cmd_pend_ff <= 1'b0;
    end else begin
      if (start) begin
        cmd_pend_ff <= 1'b0;
      end
      if (o_s_axi_awready_ff && i_s_axi_awvalid) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= i_s_axi_awaddr;
        o_s_axi_awready_ff <= 1'b0;
      end
      if (o_s_axi_wready_ff && i_s_axi_wvalid) begin
        w_hold_ff <= 1'b1;
        wdata_ff <= i_s_axi_wdata;
        wstrb_ff <= i_s_axi_wstrb;
        o_s_axi_wready_ff <= 1'b0;
      end
      if (aw_hold_ff && w_hold_ff && !o_s_axi_bvalid_ff) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        o_s_axi_bvalid_ff <= 1'b1;
        o_s_axi_bresp_ff <= `BFCI_RESP_OKAY;
        if (awaddr_ff == `BFCI_OFS_CMD) begin
          if (busy) begin
            o_s_axi_bresp_ff <= `BFCI_RESP_SLVERR;
          end else if (wstrb_ff[0]) begin
            // one bus cycle per command byte, lock commands included
            cmd_ff <= {(wstrb_ff[1] ? wdata_ff[8] : cmd_ff[8]), wdata_ff[7:0]};
            cmd_pend_ff <= 1'b1;
          end
        end else if (awaddr_ff == `BFCI_OFS_ADDR) begin
          addr_ff <= addr_new[`BFCI_ADDR_W-1:0];
        end else if (awaddr_ff == `BFCI_OFS_CTRL) begin
          pdown_ff <= ctrl_new[`BFCI_CTRL_PDOWN_BIT];
          wait_rdy_ff <= ctrl_new[`BFCI_CTRL_WAITRDY_BIT];
        end else if (awaddr_ff == `BFCI_OFS_STATUS || awaddr_ff == `BFCI_OFS_RDATA) begin
          o_s_axi_bresp_ff <= `BFCI_RESP_OKAY;
        end else begin
          o_s_axi_bresp_ff <= `BFCI_RESP_SLVERR;
        end
      end
      if (o_s_axi_bvalid_ff && i_s_axi_bready) begin
        o_s_axi_bvalid_ff <= 1'b0;
        o_s_axi_awready_ff <= 1'b1;
        o_s_axi_wready_ff <= 1'b1;
      end
    end
  end

  // axi4-lite read path
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_s_axi_arready_ff <= 1'b1;
      o_s_axi_rvalid_ff <= 1'b0;
      o_s_axi_rdata_ff <= 32'h00000000;
      o_s_axi_rresp_ff <= `BFCI_RESP_OKAY;
    end else begin
      if (o_s_axi_arready_ff && i_s_axi_arvalid) begin
        o_s_axi_arready_ff <= 1'b0;
        o_s_axi_rvalid_ff <= 1'b1;
        o_s_axi_rdata_ff <= rd_mux;
        o_s_axi_rresp_ff <= rd_err ? `BFCI_RESP_SLVERR : `BFCI_RESP_OKAY;
      end else if (o_s_axi_rvalid_ff && i_s_axi_rready) begin
        o_s_axi_rvalid_ff <= 1'b0;
        o_s_axi_arready_ff <= 1'b1;
      end
    end
  end

  // reset pin and delays after release
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reset_powerdown_n_ff <= 1'b0;
      wake_cnt_ff <= 12'h000;
      ovalid_cnt_ff <= 12'h000;
    end else begin
      // power-down only between bus cycles
      if (pdown_ff && state_ff == S_IDLE) begin
        o_reset_powerdown_n_ff <= 1'b0;
      end else if (!pdown_ff) begin
        o_reset_powerdown_n_ff <= 1'b1;
      end
      if (!o_reset_powerdown_n_ff) begin
        // reload delays while reset pin is low
        wake_cnt_ff <= wake_full[11:0];
        ovalid_cnt_ff <= ovalid_full[11:0];
      end else begin
        if (!wake_done) begin
          wake_cnt_ff <= wake_cnt_ff - 12'h001;
        end
        if (!ovalid_done) begin
          ovalid_cnt_ff <= ovalid_cnt_ff - 12'h001;
        end
      end
    end
  end

  // flash bus cycle sequencer
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff <= S_IDLE;
      cnt_ff <= 8'h00;
      cur_read_ff <= 1'b0;
      rdata_ff <= 8'h00;
      o_address_lines_ff <= 21'h0;
      o_data_lines_ff <= 8'h00;
      o_data_lines_oe_ff <= 1'b0;
      o_chip_select_n_ff <= 1'b1;
      o_output_enable_n_ff <= 1'b1;
      o_write_strobe_n_ff <= 1'b1;
    end else begin
      case (state_ff)
        S_IDLE: begin
          // deselected when idle, standby with reset high
          o_chip_select_n_ff <= 1'b1;
          o_output_enable_n_ff <= 1'b1;
          o_write_strobe_n_ff <= 1'b1;
          o_data_lines_oe_ff <= 1'b0;
          if (start) begin
            // address driven for reads and writes
            o_address_lines_ff <= addr_ff;
            o_data_lines_ff <= cmd_ff[7:0];
            cur_read_ff <= want_read;
            // host drives data only on writes
            o_data_lines_oe_ff <= !want_read;
            o_chip_select_n_ff <= 1'b0;
            cnt_ff <= setup_full[7:0];
            state_ff <= S_SETUP;
          end
        end
        S_SETUP: begin
          if (cnt_ff == 8'h01) begin
            if (cur_read_ff) begin
              // output enable low only during the read strobe
              o_output_enable_n_ff <= 1'b0;
              cnt_ff <= acc_full[7:0];
            end else begin
              o_write_strobe_n_ff <= 1'b0;
              cnt_ff <= wp_full[7:0];
            end
            state_ff <= S_STROBE;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        S_STROBE: begin
          if (cnt_ff == 8'h01) begin
            if (cur_read_ff) begin
              rdata_ff <= i_data_lines;
              o_output_enable_n_ff <= 1'b1;
            end else begin
              // rising strobe edge, address and data still stable
              o_write_strobe_n_ff <= 1'b1;
            end
            state_ff <= S_HOLD;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        S_HOLD: begin
          o_chip_select_n_ff <= 1'b1;
          o_data_lines_oe_ff <= 1'b0;
          cnt_ff <= recov_full[7:0];
          state_ff <= S_RECOV;
        end
        S_RECOV: begin
          if (cnt_ff == 8'h01) begin
            state_ff <= S_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// *** dv/bfci_flash_model.sv ***
`timescale 1ns/1ps
module bfci_flash_model #(parameter BUSY_CYC = 15) (
  // clock
  input wire i_mclk,
  // flash pins from host
  input wire [20:0] i_address_lines,
  input wire [7:0] i_data_lines,
  input wire i_chip_select_n,
  input wire i_output_enable_n,
  input wire i_write_strobe_n,
  input wire i_reset_powerdown_n,
  // flash pins to host
  output wire [7:0] o_data_lines,
  output wire o_ready_busy_out_n
);
  reg [7:0] mem [0:255]; // low bytes of one block
  reg [7:0] last_ff = 8'h00;
  reg [20:0] wr_addr = 21'h0;
  reg [7:0] wr_cnt = 8'h00;
  reg [7:0] seen_ff = 8'h00;
  reg [7:0] bad_cnt = 8'h00;
  reg [3:0] busy_ff = 4'h0;
  wire drive = !i_chip_select_n && !i_output_enable_n && i_reset_powerdown_n;
  // released lines show the inverse of the last byte
  assign o_data_lines = drive ? mem[i_address_lines[7:0]] : ~last_ff;
  assign o_ready_busy_out_n = (busy_ff == 4'h0) || !i_reset_powerdown_n;
  always @(posedge i_write_strobe_n) begin
    if (!i_chip_select_n && i_reset_powerdown_n) begin
      mem[i_address_lines[7:0]] <= i_data_lines;
      wr_addr <= i_address_lines;
      wr_cnt <= wr_cnt + 8'h01;
      if (!o_ready_busy_out_n) bad_cnt <= bad_cnt + 8'h01;
    end
  end
  always @(posedge i_mclk) begin
    seen_ff <= wr_cnt;
    if (drive) last_ff <= mem[i_address_lines[7:0]];
    if (!i_reset_powerdown_n) busy_ff <= 4'h0;
    else if (wr_cnt != seen_ff) busy_ff <= BUSY_CYC[3:0];
    else if (busy_ff != 4'h0) busy_ff <= busy_ff - 4'h1;
  end
endmodule

// *** dv/bfci_host_checker.sv ***
`timescale 1ns/1ps
module bfci_host_checker (
  // clock and reset
  input wire i_mclk,
  input wire i_reset_n,
  // flash pins
  input wire [20:0] o_address_lines_ff,
  input wire [7:0] o_data_lines_ff,
  input wire o_data_lines_oe_ff,
  input wire o_chip_select_n_ff,
  input wire o_output_enable_n_ff,
  input wire o_write_strobe_n_ff,
  input wire o_reset_powerdown_n_ff
);
  reg [3:0] up_ff;
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) up_ff <= 4'h0;
    else if (!o_reset_powerdown_n_ff) up_ff <= 4'h0;
    else if (up_ff != 4'hf) up_ff <= up_ff + 4'h1;
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  a_strobe_qual: assert property (!o_write_strobe_n_ff |-> !o_chip_select_n_ff && o_data_lines_oe_ff)
    else $error("write strobe without select or drive");
  a_read_qual: assert property (!o_output_enable_n_ff |-> !o_chip_select_n_ff && !o_data_lines_oe_ff)
    else $error("read strobe without select or with drive");
  a_strobe_width: assert property ($fell(o_write_strobe_n_ff) |=> $rose(o_write_strobe_n_ff))
    else $error("write strobe not one cycle");
  a_setup_stable: assert property ($fell(o_write_strobe_n_ff) |-> $stable(o_address_lines_ff)
    && $stable(o_data_lines_ff)) else $error("address or data moved at strobe start");
  a_hold_release: assert property ($rose(o_write_strobe_n_ff) |-> $stable(o_data_lines_ff)
    ##1 (o_chip_select_n_ff && !o_data_lines_oe_ff)) else $error("bad write hold or release");
  a_read_pulse: assert property ($fell(o_output_enable_n_ff) |=> !o_output_enable_n_ff
    ##1 o_output_enable_n_ff ##1 o_chip_select_n_ff) else $error("bad read strobe shape");
  a_pdown_idle: assert property (!o_reset_powerdown_n_ff |-> o_chip_select_n_ff && o_write_strobe_n_ff)
    else $error("bus cycle during power-down");
  a_wake_write: assert property ($fell(o_write_strobe_n_ff) |-> up_ff >= 4'ha)
    else $error("write before wake delay");
  a_wake_read: assert property ($fell(o_output_enable_n_ff) |-> up_ff >= 4'h4)
    else $error("read before output valid delay");
  a_idle_float: assert property (o_chip_select_n_ff |-> !o_data_lines_oe_ff && o_output_enable_n_ff
    && o_write_strobe_n_ff) else $error("bus driven while deselected");
endmodule
bind bfci_host bfci_host_checker chk_u (.*);

// *** dv/bfci_host_test.sv ***
`timescale 1ns/1ps
`include "bfci_consts.vh"
module bfci_host_test;
  reg i_mclk = 1'b0;
  reg i_reset_n = 1'b0;
  reg i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
  reg i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0;
  reg [7:0] i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
  reg [31:0] i_s_axi_wdata = 32'h0;
  reg [3:0] i_s_axi_wstrb = 4'hf;
  wire o_s_axi_awready_ff, o_s_axi_wready_ff, o_s_axi_bvalid_ff, o_s_axi_arready_ff, o_s_axi_rvalid_ff;
  wire [1:0] o_s_axi_bresp_ff, o_s_axi_rresp_ff;
  wire [31:0] o_s_axi_rdata_ff;
  wire [20:0] o_address_lines_ff;
  wire [7:0] o_data_lines_ff, i_data_lines, flash_dq;
  wire o_data_lines_oe_ff, o_chip_select_n_ff, o_output_enable_n_ff, o_write_strobe_n_ff;
  wire o_reset_powerdown_n_ff, i_ready_busy_out_n;
  integer fails = 0, n_tests = 0, cyc = 0, i;
  reg [31:0] rd;
  reg [1:0] rs;
  assign i_data_lines = o_data_lines_oe_ff ? o_data_lines_ff : flash_dq;
  bfci_host dut_u (.*);
  bfci_flash_model flash_u (.i_mclk(i_mclk), .i_address_lines(o_address_lines_ff), .i_data_lines(i_data_lines),
    .i_chip_select_n(o_chip_select_n_ff), .i_output_enable_n(o_output_enable_n_ff),
    .i_write_strobe_n(o_write_strobe_n_ff), .i_reset_powerdown_n(o_reset_powerdown_n_ff),
    .o_data_lines(flash_dq), .o_ready_busy_out_n(i_ready_busy_out_n));
  initial forever #50 i_mclk = ~i_mclk;
  task stop_test;
    if (fails == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      fails = fails + 1;
      stop_test;
    end
  end
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_bready <= 1'b1;
    do begin
      @(posedge i_mclk);
      if (i_s_axi_awvalid && o_s_axi_awready_ff) i_s_axi_awvalid <= 1'b0;
      if (i_s_axi_wvalid && o_s_axi_wready_ff) i_s_axi_wvalid <= 1'b0;
    end while (o_s_axi_bvalid_ff !== 1'b1);
    rs = o_s_axi_bresp_ff;
    i_s_axi_bready <= 1'b0;
  endtask
  task rdr(input logic [7:0] a);
    @(posedge i_mclk);
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_araddr <= a;
    i_s_axi_rready <= 1'b1;
    do begin
      @(posedge i_mclk);
      if (i_s_axi_arvalid && o_s_axi_arready_ff) i_s_axi_arvalid <= 1'b0;
    end while (o_s_axi_rvalid_ff !== 1'b1);
    rd = o_s_axi_rdata_ff;
    rs = o_s_axi_rresp_ff;
    i_s_axi_rready <= 1'b0;
  endtask
  task idle;
    for (i = 0; i < 60; i = i + 1) begin
      rdr(`BFCI_OFS_STATUS);
      if (rd[0] === 1'b0) i = 60;
    end
  endtask
  initial begin
    repeat (16) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    rdr(`BFCI_OFS_STATUS);
    check("wake at start", rd[2], 32'h0);
    wr(`BFCI_OFS_CTRL, 32'h2);
    wr(`BFCI_OFS_ADDR, 32'h12345);
    wr(`BFCI_OFS_CMD, 32'ha5);
    check("cmd resp", rs, `BFCI_RESP_OKAY);
    wr(`BFCI_OFS_CMD, 32'h5a);
    check("cmd while busy", rs, `BFCI_RESP_SLVERR);
    idle;
    wr(`BFCI_OFS_ADDR, 32'h00077);
    wr(`BFCI_OFS_CMD, 32'h3c);
    rdr(`BFCI_OFS_STATUS);
    check("wait on busy pin", rd[1:0], 32'h1);
    idle;
    check("write addr", flash_u.wr_addr, 32'h00077);
    check("first byte", flash_u.mem[8'h45], 32'ha5);
    check("second byte", flash_u.mem[8'h77], 32'h3c);
    check("write while busy", flash_u.bad_cnt, 32'h0);
    wr(`BFCI_OFS_ADDR, 32'h12345);
    wr(`BFCI_OFS_CMD, 32'h100);
    idle;
    rdr(`BFCI_OFS_RDATA);
    check("read byte", rd, 32'ha5);
    wr(`BFCI_OFS_CTRL, 32'h3);
    wr(`BFCI_OFS_ADDR, 32'h00010);
    wr(`BFCI_OFS_CMD, 32'h99);
    rdr(`BFCI_OFS_STATUS);
    check("pdown status", rd[4:0], 32'h13);
    wr(`BFCI_OFS_CTRL, 32'h2);
    rdr(`BFCI_OFS_STATUS);
    check("wake after pdown", rd[2], 32'h0);
    idle;
    check("byte after pdown", flash_u.mem[8'h10], 32'h99);
    rdr(`BFCI_OFS_CMD);
    check("cmd readback", rd, 32'h00000099);
    i_s_axi_wstrb <= 4'h2;
    wr(`BFCI_OFS_ADDR, 32'h00abcd55);
    i_s_axi_wstrb <= 4'hf;
    rdr(`BFCI_OFS_ADDR);
    check("addr byte strobe", rd, 32'h0000cd10);
    wr(8'h20, 32'h1);
    check("unmapped write", rs, `BFCI_RESP_SLVERR);
    rdr(8'h20);
    check("unmapped read", {rd[29:0], rs}, {30'h0, `BFCI_RESP_SLVERR});
    stop_test;
  end
endmodule
